/* File: src/sram_pkg.sv */
// constants, timing counts and state codes for the static memory host controller
// assumes a single 100 MHz clock and a 256K x 4 asynchronous memory on plain pins
// Function
// - each cycle keeps one address for at least 10 ns (fast) or 12 ns (slow grade).
// - a strobe-ended write holds the strobe low 9/10 ns, or 8/9 ns with output enable high.
// - in a strobe-ended write the address is set before the strobe falls and held until it rises.
// - write data is stable 5/6 ns before the write ends and is held up to the ending edge.
// - an enable-ended write holds enable low at least 8 ns (fast) or 9 ns (slow grade).
// - in an enable-ended write the address is set before enable falls and held until it rises.
// - the host sequences its data drivers so they never fight the memory's outputs.
// - the host keeps the write strobe high through every read cycle.
package sram_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W        = 18;
    localparam int DATA_W        = 4;
    localparam int TIMER_W       = 4;
    localparam int MON_W         = 8;

    // documented times in ns, fast grade then slow grade
    localparam int CYCLE_TIME_MIN_FAST_NS           = 10;
    localparam int CYCLE_TIME_MIN_SLOW_NS           = 12;
    localparam int STROBE_PULSE_WIDTH_FAST_NS       = 8;   // output enable held high
    localparam int STROBE_PULSE_WIDTH_SLOW_NS       = 9;
    localparam int ADDR_VALID_TO_STROBE_END_FAST_NS = 8;
    localparam int ADDR_VALID_TO_STROBE_END_SLOW_NS = 9;
    localparam int ENABLE_PULSE_WIDTH_FAST_NS       = 8;
    localparam int ENABLE_PULSE_WIDTH_SLOW_NS       = 9;
    localparam int ADDR_VALID_TO_ENABLE_END_FAST_NS = 8;
    localparam int ADDR_VALID_TO_ENABLE_END_SLOW_NS = 9;
    localparam int DATA_SETUP_TO_STROBE_END_FAST_NS = 5;
    localparam int DATA_SETUP_TO_STROBE_END_SLOW_NS = 6;
    localparam int READ_ACCESS_FAST_NS              = 10;
    localparam int READ_ACCESS_SLOW_NS              = 12;

    // least times round up, never below one cycle
    function automatic int cyc_min(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) c = 1;
        return c;
    endfunction : cyc_min

    function automatic int max3(input int a, input int b, input int c);
        int m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction : max3

    localparam int CYCLE_CYC_FAST  = cyc_min(CYCLE_TIME_MIN_FAST_NS);
    localparam int CYCLE_CYC_SLOW  = cyc_min(CYCLE_TIME_MIN_SLOW_NS);
    localparam int STROBE_CYC_FAST = max3(cyc_min(STROBE_PULSE_WIDTH_FAST_NS),
        cyc_min(ADDR_VALID_TO_STROBE_END_FAST_NS), cyc_min(DATA_SETUP_TO_STROBE_END_FAST_NS));
    localparam int STROBE_CYC_SLOW = max3(cyc_min(STROBE_PULSE_WIDTH_SLOW_NS),
        cyc_min(ADDR_VALID_TO_STROBE_END_SLOW_NS), cyc_min(DATA_SETUP_TO_STROBE_END_SLOW_NS));
    localparam int ENABLE_CYC_FAST = max3(cyc_min(ENABLE_PULSE_WIDTH_FAST_NS),
        cyc_min(ADDR_VALID_TO_ENABLE_END_FAST_NS), cyc_min(DATA_SETUP_TO_STROBE_END_FAST_NS));
    localparam int ENABLE_CYC_SLOW = max3(cyc_min(ENABLE_PULSE_WIDTH_SLOW_NS),
        cyc_min(ADDR_VALID_TO_ENABLE_END_SLOW_NS), cyc_min(DATA_SETUP_TO_STROBE_END_SLOW_NS));
    // one extra cycle so the sampling edge lies clearly past the access time
    localparam int READ_CYC_FAST   = cyc_min(READ_ACCESS_FAST_NS) + 1;
    localparam int READ_CYC_SLOW   = cyc_min(READ_ACCESS_SLOW_NS) + 1;

    // pin levels held after reset
    localparam logic PIN_IDLE_N = 1'b1;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_SETUP   = 6'h02,
        ST_PULSE   = 6'h04,
        ST_RECOVER = 6'h08,
        ST_READ    = 6'h10,
        ST_TURN    = 6'h20
    } host_state_e;
endpackage : sram_pkg

/* File: src/pulse_timer.sv */
// down-counter that times one phase of a memory cycle
// assumes load is a one-cycle request; done stays high once the count runs out
`timescale 1ns/1ns
module pulse_timer #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    logic [W-1:0] count_reg;

    // a load of n gives done after n cycles in the phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_val - W'(1);
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    assign done = (count_reg == '0) && !load;
endmodule : pulse_timer

/* File: src/sram_host.sv */
// host controller for an asynchronous 256K x 4 static memory with common data pins
// assumes memory pins are synchronous to clk and external pads resolve dq from dq_oe_n
`timescale 1ns/1ns
module sram_host
    import sram_pkg::*;
#(
    parameter bit SLOW_GRADE = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic              req_by_enable,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_en_n,
    output logic                   mem_we_n,
    output logic                   mem_oe_n,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_n,
    input  wire logic [DATA_W-1:0] dq_in
);
    localparam int CYCLE_CYC  = SLOW_GRADE ? CYCLE_CYC_SLOW  : CYCLE_CYC_FAST;
    localparam int STROBE_CYC = SLOW_GRADE ? STROBE_CYC_SLOW : STROBE_CYC_FAST;
    localparam int ENABLE_CYC = SLOW_GRADE ? ENABLE_CYC_SLOW : ENABLE_CYC_FAST;
    localparam int READ_CYC   = SLOW_GRADE ? READ_CYC_SLOW   : READ_CYC_FAST;

    host_state_e       state_reg;
    logic              mode_reg;      // 1: enable ends the write
    logic              req_ready_reg;
    logic              rsp_valid_reg;
    logic [DATA_W-1:0] rsp_rdata_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic              mem_en_n_reg;
    logic              mem_we_n_reg;
    logic              mem_oe_n_reg;
    logic [DATA_W-1:0] dq_out_reg;
    logic              dq_oe_n_reg;
    logic              take;
    logic              tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic              tmr_done;

    assign take = (state_reg == ST_IDLE) && req_ready_reg && req_valid;

    // phase timer loads on entry to the strobe pulse and the read access
    assign tmr_load = (state_reg == ST_SETUP) || (take && !req_write);
    assign tmr_val  = (state_reg == ST_SETUP) ?
                      (mode_reg ? TIMER_W'(ENABLE_CYC) : TIMER_W'(STROBE_CYC)) :
                      TIMER_W'(READ_CYC);

    pulse_timer #(
        .W (TIMER_W)
    ) u_timer (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // cycle sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            mode_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (take) begin
                        mode_reg  <= req_by_enable;
                        state_reg <= req_write ? ST_SETUP : ST_READ;
                    end
                end
                ST_SETUP:   state_reg <= ST_PULSE;
                ST_PULSE:   if (tmr_done) state_reg <= ST_RECOVER;
                ST_RECOVER: state_reg <= ST_IDLE;
                ST_READ:    if (tmr_done) state_reg <= ST_TURN;
                ST_TURN:    state_reg <= ST_IDLE;
            endcase
        end
    end

    // address only moves on a take, so it is steady across every strobe edge except the strobe fall at the take of an enable write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_addr_reg <= '0;
        end else if (take) begin
            mem_addr_reg <= req_addr;
        end
    end

    // chip enable: low from the setup in strobe writes, only for the pulse in enable writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_en_n_reg <= PIN_IDLE_N;
        end else if (take) begin
            mem_en_n_reg <= req_write && req_by_enable;
        end else if (state_reg == ST_SETUP && mode_reg) begin
            mem_en_n_reg <= 1'b0;
        end else if (state_reg == ST_PULSE && tmr_done && mode_reg) begin
            mem_en_n_reg <= 1'b1;
        end else if (state_reg == ST_RECOVER || (state_reg == ST_READ && tmr_done)) begin
            mem_en_n_reg <= 1'b1;
        end
    end

    // write strobe: in enable writes it falls first and rises last, keeping dq floating
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_we_n_reg <= PIN_IDLE_N;
        end else if (take) begin
            mem_we_n_reg <= !(req_write && req_by_enable);
        end else if (state_reg == ST_SETUP && !mode_reg) begin
            mem_we_n_reg <= 1'b0;
        end else if (state_reg == ST_PULSE && tmr_done && !mode_reg) begin
            mem_we_n_reg <= 1'b1;
        end else if (state_reg == ST_RECOVER) begin
            mem_we_n_reg <= 1'b1;
        end
    end

    // output enable stays high in writes, which allows the shorter strobe pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_oe_n_reg <= PIN_IDLE_N;
        end else if (take) begin
            mem_oe_n_reg <= req_write;
        end else if (state_reg == ST_READ && tmr_done) begin
            mem_oe_n_reg <= 1'b1;
        end
    end

    // data driven from setup through recover; the turn state gives the memory time to float
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_out_reg  <= '0;
            dq_oe_n_reg <= PIN_IDLE_N;
        end else if (take && req_write) begin
            dq_out_reg  <= req_wdata;
            dq_oe_n_reg <= 1'b0;
        end else if (state_reg == ST_RECOVER) begin
            dq_oe_n_reg <= 1'b1;       // zero hold needed past the ending edge
        end
    end

    // handshake toward the user side
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= '0;
        end else begin
            req_ready_reg <= (state_reg == ST_IDLE && !take) ||
                             state_reg == ST_RECOVER || state_reg == ST_TURN;
            rsp_valid_reg <= (state_reg == ST_READ) && tmr_done;
            if (state_reg == ST_READ && tmr_done) begin
                rsp_rdata_reg <= dq_in;
            end
        end
    end

    assign req_ready = req_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign mem_addr  = mem_addr_reg;
    assign mem_en_n  = mem_en_n_reg;
    assign mem_we_n  = mem_we_n_reg;
    assign mem_oe_n  = mem_oe_n_reg;
    assign dq_out    = dq_out_reg;
    assign dq_oe_n   = dq_oe_n_reg;

    // monitor counters read only by the checks below
    logic [MON_W-1:0] we_low_cnt;
    logic [MON_W-1:0] en_low_cnt;
    logic [MON_W-1:0] addr_age;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            we_low_cnt <= '0;
            en_low_cnt <= '0;
            addr_age   <= '0;
        end else begin
            we_low_cnt <= mem_we_n_reg ? '0 : we_low_cnt + MON_W'(we_low_cnt != '1);
            en_low_cnt <= mem_en_n_reg ? '0 : en_low_cnt + MON_W'(en_low_cnt != '1);
            addr_age   <= take ? '0 : addr_age + MON_W'(addr_age != '1);
        end
    end

    chk_read_strobe_high: assert property (@(posedge clk) disable iff (sys_rst)
        (!mem_oe_n_reg && !mem_en_n_reg) |-> mem_we_n_reg)
        else $error("write strobe low during a read");
    chk_strobe_width: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(mem_we_n_reg) && !mode_reg) |-> (we_low_cnt >= MON_W'(STROBE_CYC)))
        else $error("write strobe pulse too short");
    chk_enable_width: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(mem_en_n_reg) && mode_reg && !$past(mem_we_n_reg))
        |-> (en_low_cnt >= MON_W'(ENABLE_CYC)))
        else $error("enable pulse too short in enable write");
    chk_addr_strobe_fall: assert property (@(posedge clk) disable iff (sys_rst)
        ($fell(mem_we_n_reg) && !mode_reg) |-> $stable(mem_addr_reg))
        else $error("address changed at strobe fall");
    chk_addr_enable_fall: assert property (@(posedge clk) disable iff (sys_rst)
        ($fell(mem_en_n_reg) && mode_reg && !mem_we_n_reg) |-> $stable(mem_addr_reg))
        else $error("address changed at enable fall");
    chk_addr_held_write: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(mem_addr_reg) |-> ($past(mem_we_n_reg) && $past(mem_en_n_reg)))
        else $error("address changed inside a write overlap");
    chk_data_stable: assert property (@(posedge clk) disable iff (sys_rst)
        (!mem_we_n_reg && !mem_en_n_reg) |-> (!dq_oe_n_reg && $stable(dq_out_reg)))
        else $error("write data not stable during overlap");
    chk_data_setup: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_PULSE && tmr_done) |-> (!$past(dq_oe_n_reg) && !dq_oe_n_reg))
        else $error("write data not set up before write end");
    chk_no_contention: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(dq_oe_n_reg) |-> ($past(mem_oe_n_reg) && mem_oe_n_reg))
        else $error("host drives dq while memory may drive");
    chk_cycle_time: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(mem_addr_reg) |-> ($past(addr_age) >= MON_W'(CYCLE_CYC - 1)))
        else $error("cycle shorter than minimum");
    chk_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
        (take && !req_write) |-> ##(READ_CYC + 1) rsp_valid_reg)
        else $error("read answer late or missing");

    cov_strobe_write: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(mem_we_n_reg) && !mode_reg);
    cov_enable_write: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(mem_en_n_reg) && mode_reg && !mem_we_n_reg);
    cov_read_done: cover property (@(posedge clk) disable iff (sys_rst) rsp_valid_reg);
    cov_read_then_write: cover property (@(posedge clk) disable iff (sys_rst)
        rsp_valid_reg ##[1:4] (take && req_write));
endmodule : sram_host

/* File: tb/sram_model.sv */
// behavioural model of the 256K x 4 static memory seen from its pins
// assumes the bench resolves the shared data wire and feeds it back as dq_wire
`timescale 1ns/1ns
module sram_model
    import sram_pkg::*;
(
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_en_n,
    input  wire logic              mem_we_n,
    input  wire logic              mem_oe_n,
    input  wire logic [DATA_W-1:0] dq_wire,
    output logic [DATA_W-1:0]      q_out,
    output logic                   q_oe_n
);
    logic [DATA_W-1:0] store [logic [ADDR_W-1:0]];
    logic              drive;

    // stores throughout the overlap, so the word present when either strobe rises wins
    always @(mem_en_n, mem_we_n, mem_addr, dq_wire) begin
        if (mem_en_n === 1'b0 && mem_we_n === 1'b0) begin
            store[mem_addr] = dq_wire;
        end
    end

    // blank words read back as the inverted low address bits, never as a stale value
    always @(mem_addr, mem_en_n, mem_we_n, dq_wire) begin
        if (store.exists(mem_addr))
            q_out = store[mem_addr];
        else
            q_out = ~mem_addr[DATA_W-1:0];
    end

    // drives only when selected, output enabled and not writing
    assign drive = (mem_en_n === 1'b0) && (mem_oe_n === 1'b0) && (mem_we_n === 1'b1);
    // floats at once, re-drives 3 ns late: float is always quicker than re-drive
    assign #(0, 3) q_oe_n = !drive;
endmodule : sram_model

/* File: tb/testbench.sv */
// self-checking bench for the static memory host controller, fast grade
// assumes the memory model in sram_model and a data wire resolved here
`timescale 1ns/1ns
module testbench
    import sram_pkg::*;
;
    // pin walks per cycle after the take: {en_n, we_n, oe_n, dq_oe_n, req_ready}
    localparam logic [19:0] WALK_STROBE = {5'h0C, 5'h04, 5'h0C, 5'h1F};
    localparam logic [19:0] WALK_ENABLE = {5'h14, 5'h04, 5'h14, 5'h1F};
    localparam logic [19:0] WALK_READ   = {5'h0A, 5'h0A, 5'h1E, 5'h1F};

    logic              clk;
    logic              sys_rst;
    logic              req_valid;
    logic              req_write;
    logic              req_by_enable;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic              req_ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic [ADDR_W-1:0] mem_addr;
    logic              mem_en_n;
    logic              mem_we_n;
    logic              mem_oe_n;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] q_out;
    logic              q_oe_n;
    logic [DATA_W-1:0] dq_last;
    logic [4:0]        pins;
    int                error_cnt;
    int                checks_done;
    int                cyc;

    sram_host dut_u (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_by_enable(req_by_enable), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_en_n(mem_en_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in));
    sram_model mem_u (.mem_addr(mem_addr), .mem_en_n(mem_en_n), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .dq_wire(dq_in), .q_out(q_out), .q_oe_n(q_oe_n));

    // undriven wire shows a value flipped every cycle, so a stale sample cannot match
    assign dq_in = (dq_oe_n === 1'b0) ? dq_out : ((q_oe_n === 1'b0) ? q_out : ~dq_last);
    assign pins = {mem_en_n, mem_we_n, mem_oe_n, dq_oe_n, req_ready};

    always #5 clk = ~clk;

    always @(posedge clk) begin
        dq_last <= dq_in;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // host and memory never drive the shared wire together
    always @(negedge clk) begin
        if (!sys_rst)
            check(dq_oe_n | q_oe_n, 1'b1);
    end

    // one request, then the pins of the four cycles after the take
    task automatic xfer(input logic w, input logic e, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [19:0] walk,
                        input logic [DATA_W-1:0] rexp);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(req_ready, 1'b1);
        req_valid = 1'b1;
        req_write = w;
        req_by_enable = e;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
        // the first look falls in the cycle right after the take, where req_valid drops
        for (int k = 1; k <= 4; k++) begin
            if (k > 1)
                @(negedge clk);
            check(pins, walk[24-5*k -: 5]);
            check(rsp_valid, !w && k == READ_CYC_FAST + 1);
            if (k < 4)
                check(mem_addr, a);
            if (w && k < 4)
                check(dq_out, d);
            if (!w && k == READ_CYC_FAST + 1)
                check(rsp_rdata, rexp);
        end
    endtask : xfer

    task automatic test_reset();
        check(pins, 5'h1E);
        check({rsp_valid, rsp_rdata, dq_out, mem_addr}, 0);
    endtask : test_reset

    task automatic test_strobe_write();
        xfer(1'b1, 1'b0, 18'h3FFFF, 4'hA, WALK_STROBE, 4'h0);
        xfer(1'b0, 1'b0, 18'h3FFFF, 4'h0, WALK_READ, 4'hA);
    endtask : test_strobe_write

    task automatic test_enable_write();
        xfer(1'b1, 1'b1, 18'h00000, 4'h5, WALK_ENABLE, 4'h0);
        xfer(1'b0, 1'b1, 18'h00000, 4'h0, WALK_READ, 4'h5);
        xfer(1'b0, 1'b0, 18'h3FFFF, 4'h0, WALK_READ, 4'hA);
    endtask : test_enable_write

    // write, rewrite by the other ending, read back without gaps
    task automatic test_overwrite();
        xfer(1'b1, 1'b0, 18'h12345, 4'hC, WALK_STROBE, 4'h0);
        xfer(1'b1, 1'b1, 18'h12345, 4'h3, WALK_ENABLE, 4'h0);
        xfer(1'b0, 1'b0, 18'h12345, 4'h0, WALK_READ, 4'h3);
        xfer(1'b0, 1'b0, 18'h2AAAA, 4'h0, WALK_READ, 4'h5);
    endtask : test_overwrite

    // bounded run: a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_by_enable = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        dq_last = '0;
        error_cnt = 0;
        checks_done = 0;
        cyc = 0;
        repeat (3) @(negedge clk);
        test_reset();
        sys_rst = 1'b0;
        test_strobe_write();
        test_enable_write();
        test_overwrite();
        conclude();
    end
endmodule : testbench
